// [btc_map.svh]
// Constants for the block transfer controller: instruction codes and sizes
// Assumes inclusion by bare name from the package and design modules
`ifndef BTC_MAP_SVH
`define BTC_MAP_SVH
`define BTC_WORD_W 18
`define BTC_ADDR_W 15
`define BTC_DEV_W 6
`define BTC_FUNC_W 3
`define BTC_OWN_DEV 6'h0_020
// External control functions
`define BTC_EXC_START 3'h0_000
`define BTC_EXC_INIT 3'h0_004
// Transfer functions, eleven in all
`define BTC_XFR_LD_FIRST 4'h0_000
`define BTC_XFR_LD_FINAL 4'h0_001
`define BTC_XFR_LD_DEV 4'h0_002
`define BTC_XFR_RD_CUR 4'h0_003
`define BTC_XFR_RD_FINAL 4'h0_004
`define BTC_XFR_RD_DEV 4'h0_005
`define BTC_XFR_RD_STAT 4'h0_006
`define BTC_XFR_LD_DIR 4'h0_007
`define BTC_XFR_RD_DIR 4'h0_008
`define BTC_XFR_CLR_ABN 4'h0_009
`define BTC_XFR_STOP 4'h0_00A
`define BTC_XFR_COUNT 11
// Sense functions
`define BTC_SEN_READY 3'h0_001
`define BTC_SEN_ABNORMAL 3'h0_002
// Sustained rate 202,000 words per second at 125 MHz clock
`define BTC_RATE_WPS 202000
`define BTC_CLK_HZ 125000000
`define BTC_MIN_GAP ((`BTC_CLK_HZ + `BTC_RATE_WPS - 1) / `BTC_RATE_WPS)
`endif

// [btc_pkg.sv]
// Types shared by the block transfer controller modules
// Assumes btc_map.svh is on the include path
`include "btc_map.svh"
package btc_pkg;
  typedef logic [`BTC_ADDR_W-1:0] btc_addr_t;
  typedef logic [`BTC_WORD_W-1:0] btc_word_t;
  typedef logic [`BTC_DEV_W-1:0] btc_dev_t;
  typedef enum logic [1:0] {BTC_CMD_NONE, BTC_CMD_EXC, BTC_CMD_XFR, BTC_CMD_SEN} btc_cmd_e;
  typedef enum {BTC_IDLE, BTC_ARMED, BTC_MEM, BTC_DONE} btc_state_e;
endpackage

// [btc_dec_if.sv]
// Carrier between instruction decoder and sequence core
// Assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface btc_dec_if;
  import btc_pkg::*;
  btc_cmd_e cmd;
  logic [3:0] func;
  modport dec (output cmd, output func);
  modport core (input cmd, input func);
endinterface

// [btc_decode.sv]
// Decodes host I/O cable instructions addressed to this controller
// Assumes instruction strobe, device number and function are synchronous
`timescale 1ns/1ps
module btc_decode (
  // Host cable
  input wire logic instrStb,
  input wire btc_pkg::btc_cmd_e instrKind,
  input wire btc_pkg::btc_dev_t instrDev,
  input wire logic [3:0] instrFunc,
  input wire btc_pkg::btc_dev_t ownDev,
  // To core
  btc_dec_if.dec dec
);
  import btc_pkg::*;
  wire logic hit;
  wire logic legal;
  function automatic logic isLegal(input btc_cmd_e k, input logic [3:0] f);
    case (k)
      BTC_CMD_EXC: isLegal = f == {1'b0, `BTC_EXC_START} || f == {1'b0, `BTC_EXC_INIT};
      BTC_CMD_XFR: isLegal = f < 4'(`BTC_XFR_COUNT);
      BTC_CMD_SEN: isLegal = f == {1'b0, `BTC_SEN_READY} || f == {1'b0, `BTC_SEN_ABNORMAL};
      default: isLegal = 1'b0;
    endcase
  endfunction
  assign hit = instrStb && instrDev == ownDev;
  assign legal = isLegal(instrKind, instrFunc);
  assign dec.cmd = (hit && legal) ? instrKind : BTC_CMD_NONE;
  assign dec.func = instrFunc;
endmodule

// [btc_core.sv]
// Block transfer controller: address control, sequencing and host decode
// Assumes memory acks each request once; peripheral holds request until ack
//
// Behaviour
// - Hold current and final block addresses
// - Move words only on peripheral request
// - End transfer itself after last word
// - Peripheral stop ends transfer at once
// - Sense connection and abnormal stop
// - Decode two control, eleven transfer, two sense
// - Attach to host cable like any peripheral
// - Drive and accept transfer cable handshakes
// - Supply address and move one item
// - Release peripheral on completion or stop
// - Full-width words at up to rated speed
// - Several controllers share cable by priority
`timescale 1ns/1ps
`include "btc_map.svh"
module btc_core #(
  parameter int WORD_W = `BTC_WORD_W,
  parameter btc_pkg::btc_dev_t OWN_DEV = `BTC_OWN_DEV,
  parameter int MIN_GAP = `BTC_MIN_GAP
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Host I/O cable instructions
  input wire logic instrStb,
  input wire btc_pkg::btc_cmd_e instrKind,
  input wire btc_pkg::btc_dev_t instrDev,
  input wire logic [3:0] instrFunc,
  input wire logic [WORD_W-1:0] hostDataIn,
  output logic [WORD_W-1:0] hostDataOut,
  output logic hostDataValid,
  output logic senseTrue,
  // Priority chain on the host cable
  input wire logic prioIn,
  output logic prioOut,
  // Memory access port
  output logic memReq,
  output logic memWrite,
  output btc_pkg::btc_addr_t memAddr,
  output logic [WORD_W-1:0] memWData,
  input wire logic memAck,
  input wire logic [WORD_W-1:0] memRData,
  // Transfer cable to peripherals
  output btc_pkg::btc_dev_t selDev,
  output logic selActive,
  input wire logic periphConnected,
  input wire logic periphReq,
  input wire logic periphStop,
  input wire logic [WORD_W-1:0] periphDataIn,
  output logic [WORD_W-1:0] periphDataOut,
  output logic periphAck,
  output logic blockDone
);
  import btc_pkg::*;
  btc_dec_if decBus();
  btc_decode uDec (
    .instrStb(instrStb),
    .instrKind(instrKind),
    .instrDev(instrDev),
    .instrFunc(instrFunc),
    .ownDev(OWN_DEV),
    .dec(decBus)
  );
  btc_state_e state_reg, state_next;
  btc_addr_t cur_reg;
  btc_addr_t final_reg;
  btc_dev_t dev_reg;
  logic toMem_reg;
  logic abn_reg;
  logic act_reg;
  logic [WORD_W-1:0] hostOut_reg;
  logic [WORD_W-1:0] pOut_reg;
  logic [WORD_W-1:0] mData_reg;
  logic hostVal_reg;
  logic sense_reg;
  logic ack_reg;
  logic done_reg;
  logic memReq_reg;
  logic prio_reg;
  logic [15:0] gap_reg;
  // Instruction decode
  wire logic isExc = decBus.cmd == BTC_CMD_EXC;
  wire logic isXfr = decBus.cmd == BTC_CMD_XFR;
  wire logic isSen = decBus.cmd == BTC_CMD_SEN;
  wire logic doInit = rst || (isExc && decBus.func == {1'b0, `BTC_EXC_INIT});
  wire logic doStart = isExc && decBus.func == {1'b0, `BTC_EXC_START} && state_reg == BTC_IDLE;
  wire logic doHalt = isXfr && decBus.func == `BTC_XFR_STOP;
  wire logic isLdFirst = isXfr && decBus.func == `BTC_XFR_LD_FIRST;
  wire logic isLdFinal = isXfr && decBus.func == `BTC_XFR_LD_FINAL;
  wire logic isLdDev = isXfr && decBus.func == `BTC_XFR_LD_DEV;
  wire logic isLdDir = isXfr && decBus.func == `BTC_XFR_LD_DIR;
  wire logic isRdCur = isXfr && decBus.func == `BTC_XFR_RD_CUR;
  wire logic isRdFinal = isXfr && decBus.func == `BTC_XFR_RD_FINAL;
  wire logic isRdDev = isXfr && decBus.func == `BTC_XFR_RD_DEV;
  wire logic isRdDir = isXfr && decBus.func == `BTC_XFR_RD_DIR;
  wire logic isRdStat = isXfr && decBus.func == `BTC_XFR_RD_STAT;
  wire logic isClrAbn = isXfr && decBus.func == `BTC_XFR_CLR_ABN;
  // Sequence conditions
  wire logic busy = state_reg != BTC_IDLE;
  wire logic lastWord = cur_reg == final_reg;
  wire logic gapOk = gap_reg == 16'h0_000;
  // Skip ack cycle, request may be stale
  wire logic takeReq = state_reg == BTC_ARMED && periphReq && prioIn && gapOk && !periphStop && !ack_reg;
  wire logic stopNow = busy && periphStop;
  wire logic wordDone = state_reg == BTC_MEM && memAck;
  // Host read and sense selection
  wire logic [WORD_W-1:0] rdSel =
    isRdCur ? WORD_W'(cur_reg) :
    isRdFinal ? WORD_W'(final_reg) :
    isRdDev ? WORD_W'(dev_reg) :
    isRdDir ? WORD_W'(toMem_reg) :
    isRdStat ? WORD_W'({abn_reg, busy}) : '0;
  wire logic rdHit = isRdCur || isRdFinal || isRdDev || isRdDir || isRdStat;
  wire logic senVal = decBus.func == {1'b0, `BTC_SEN_READY} ? (busy && periphConnected) : abn_reg;
  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BTC_IDLE: if (doStart) state_next = BTC_ARMED;
      BTC_ARMED: if (takeReq) state_next = BTC_MEM;
      BTC_MEM: if (wordDone) state_next = lastWord ? BTC_DONE : BTC_ARMED;
      BTC_DONE: state_next = BTC_IDLE;
      default: state_next = BTC_IDLE;
    endcase
    if (stopNow || doHalt || doInit) state_next = BTC_IDLE;
  end
  // State and transfer-active flag
  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
    act_reg <= state_next != BTC_IDLE;
  end
  // Current address
  always_ff @(posedge ref_clk) begin
    if (doInit) cur_reg <= '0;
    else if (isLdFirst && !busy) cur_reg <= btc_addr_t'(hostDataIn);
    else if (wordDone && !lastWord) cur_reg <= cur_reg + 1'b1;
  end
  // Final address
  always_ff @(posedge ref_clk) begin
    if (doInit) final_reg <= '0;
    else if (isLdFinal && !busy) final_reg <= btc_addr_t'(hostDataIn);
  end
  // Selected device
  always_ff @(posedge ref_clk) begin
    if (doInit) dev_reg <= '0;
    else if (isLdDev && !busy) dev_reg <= btc_dev_t'(hostDataIn);
  end
  // Direction
  always_ff @(posedge ref_clk) begin
    if (doInit) toMem_reg <= 1'b0;
    else if (isLdDir && !busy) toMem_reg <= hostDataIn[0];
  end
  // Abnormal stop flag
  always_ff @(posedge ref_clk) begin
    if (doInit) abn_reg <= 1'b0;
    else if (stopNow) abn_reg <= 1'b1;
    else if (isClrAbn) abn_reg <= 1'b0;
  end
  // Host read data and sense
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hostOut_reg <= '0;
      hostVal_reg <= 1'b0;
      sense_reg <= 1'b0;
    end else begin
      hostVal_reg <= rdHit;
      hostOut_reg <= rdHit ? rdSel : '0;
      sense_reg <= isSen && senVal;
    end
  end
  // Memory request and peripheral handshake
  always_ff @(posedge ref_clk) begin
    if (doInit || stopNow) begin
      memReq_reg <= 1'b0;
      ack_reg <= 1'b0;
      done_reg <= 1'b0;
      gap_reg <= '0;
      pOut_reg <= '0;
      mData_reg <= '0;
    end else begin
      ack_reg <= 1'b0;
      done_reg <= wordDone && lastWord;
      if (takeReq) begin
        memReq_reg <= 1'b1;
        mData_reg <= periphDataIn;
        gap_reg <= 16'(MIN_GAP - 1);
      end else if (gap_reg != 16'h0_000) begin
        gap_reg <= gap_reg - 1'b1;
      end
      if (wordDone) begin
        memReq_reg <= 1'b0;
        ack_reg <= 1'b1;
        if (!toMem_reg) pOut_reg <= memRData;
      end
      if (doHalt) memReq_reg <= 1'b0;
    end
  end
  // Priority pass-on
  always_ff @(posedge ref_clk) begin
    prio_reg <= rst ? 1'b0 : (prioIn && !(state_reg == BTC_ARMED && periphReq));
  end
  // Outputs
  assign hostDataOut = hostOut_reg;
  assign hostDataValid = hostVal_reg;
  assign senseTrue = sense_reg;
  assign prioOut = prio_reg;
  assign memReq = memReq_reg;
  assign memWrite = toMem_reg;
  assign memAddr = cur_reg;
  assign memWData = mData_reg;
  assign selDev = dev_reg;
  assign selActive = act_reg;
  assign periphDataOut = pOut_reg;
  assign periphAck = ack_reg;
  assign blockDone = done_reg;
endmodule

// [btc_core_props.sv]
// Port assertions for the block transfer controller
// Assumes a bind onto btc_core, one clock domain
`timescale 1ns/1ps
module btc_core_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire logic prioIn,
  input wire logic memReq,
  input wire logic memAck,
  input wire logic periphReq,
  input wire logic periphStop,
  input wire logic periphAck,
  input wire logic selActive,
  input wire logic blockDone
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_take; !memReq ##1 memReq; endsequence
  sequence s_word; memReq && memAck; endsequence
  property p_pace; s_take |-> $past(periphReq); endproperty
  property p_prio; s_take |-> $past(prioIn); endproperty
  property p_word; s_word |=> !memReq; endproperty
  property p_ack; periphAck |-> $past(memAck); endproperty
  property p_pulse; periphAck |=> !periphAck; endproperty
  property p_stop; selActive && periphStop |=> !selActive && !memReq; endproperty
  property p_done; blockDone |-> $past(memAck) ##1 !selActive; endproperty
  property p_idle; !selActive |-> !memReq; endproperty
  a_pace: assert property (p_pace) else $error("memory request without peripheral request");
  a_prio: assert property (p_prio) else $error("memory request without priority");
  a_word: assert property (p_word) else $error("memory request held after ack");
  a_ack: assert property (p_ack) else $error("peripheral ack without memory ack");
  a_pulse: assert property (p_pulse) else $error("peripheral ack longer than one cycle");
  a_stop: assert property (p_stop) else $error("transfer kept after stop");
  a_done: assert property (p_done) else $error("block end out of step");
  a_idle: assert property (p_idle) else $error("memory request while idle");
endmodule
bind btc_core btc_core_props u_props (.ref_clk, .rst, .prioIn, .memReq, .memAck, .periphReq, .periphStop,
  .periphAck, .selActive, .blockDone);

// [btc_periph_model.sv]
// Peripheral controller model on the transfer cable
// Assumes the controller acks each held request once
`timescale 1ns/1ps
module btc_periph_model (
  // Clock
  input wire logic ref_clk,
  // Bench control
  input wire logic go,
  // Transfer cable
  input wire logic periphAck,
  output logic periphReq,
  output logic [17:0] periphDataIn
);
  logic [17:0] cnt;
  initial begin
    periphReq = 1'b0;
    periphDataIn = 18'h0_0000;
    cnt = 18'h0_0001;
  end
  always @(posedge ref_clk) begin
    if (periphReq && periphAck) begin
      periphReq <= 1'b0;
      periphDataIn <= ~periphDataIn;
    end else if (go && !periphReq) begin
      periphReq <= 1'b1;
      periphDataIn <= cnt;
      cnt <= cnt + 18'h0_0001;
    end
  end
endmodule

// [block_transfer_interlace_tb_top.sv]
// Self-checking bench for the block transfer controller
// Assumes btc_pkg, the checker and the peripheral model are compiled first
`timescale 1ns/1ps
`include "btc_map.svh"
module block_transfer_interlace_tb_top;
  import btc_pkg::*;
  localparam btc_word_t NIL = 18'h0_0000;
  logic ref_clk, rst, instrStb, prioIn, memAck, periphConnected, periphStop, go, hostDataValid, senseTrue;
  logic prioOut, memReq, memWrite, periphReq, periphAck, blockDone, selActive, rv, sv;
  btc_cmd_e instrKind;
  btc_dev_t instrDev, selDev;
  logic [3:0] instrFunc;
  btc_word_t hostDataIn, hostDataOut, memWData, memRData, periphDataIn, periphDataOut, rd;
  btc_addr_t memAddr;
  int fails, n_tests, cyc, words, nDone;
  btc_core #(.MIN_GAP(2)) dut (.ref_clk, .rst, .instrStb, .instrKind, .instrDev, .instrFunc, .hostDataIn,
    .hostDataOut, .hostDataValid, .senseTrue, .prioIn, .prioOut, .memReq, .memWrite, .memAddr, .memWData,
    .memAck, .memRData, .selDev, .selActive, .periphConnected, .periphReq, .periphStop, .periphDataIn,
    .periphDataOut, .periphAck, .blockDone);
  btc_periph_model peer (.ref_clk, .go, .periphAck, .periphReq, .periphDataIn);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input btc_word_t e, input btc_word_t g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Memory answers, word monitor and hang limit
  always @(posedge ref_clk) begin
    memAck <= memReq && !memAck;
    memRData <= {3'h0, memAddr};
    cyc <= cyc + 1;
    if (blockDone) nDone <= nDone + 1;
    if (memReq && memAck) begin
      words <= words + 1;
      chk("memWData", words + 1, memWData);
    end
    if (cyc == 5000) begin
      fails++;
      give_verdict;
    end
  end
  task automatic op(input btc_cmd_e k, input logic [3:0] f, input btc_word_t d);
    @(posedge ref_clk);
    instrStb <= 1'b1;
    instrKind <= k;
    instrFunc <= f;
    hostDataIn <= d;
    @(posedge ref_clk);
    instrStb <= 1'b0;
    #1;
    rd = hostDataOut;
    rv = hostDataValid;
    sv = senseTrue;
  endtask
  task automatic setup(input btc_word_t a, input btc_word_t b, input logic dir);
    op(BTC_CMD_XFR, `BTC_XFR_LD_FIRST, a);
    op(BTC_CMD_XFR, `BTC_XFR_LD_FINAL, b);
    op(BTC_CMD_XFR, `BTC_XFR_LD_DEV, 18'h0_0003);
    op(BTC_CMD_XFR, `BTC_XFR_LD_DIR, btc_word_t'(dir));
    op(BTC_CMD_XFR, `BTC_XFR_RD_CUR, NIL);
    chk("valid", 1, rv);
    chk("cur", a, rd);
    chk("selDev", 18'h0_0003, selDev);
    chk("memWrite", btc_word_t'(dir), memWrite);
    op(BTC_CMD_EXC, `BTC_EXC_START, NIL);
  endtask
  task automatic t_block;
    chk("idle", 0, selActive);
    setup(18'h0_0005, 18'h0_0007, 1'b1);
    op(BTC_CMD_SEN, `BTC_SEN_READY, NIL);
    chk("ready", 1, sv);
    @(posedge ref_clk);
    periphConnected <= 1'b0;
    op(BTC_CMD_SEN, `BTC_SEN_READY, NIL);
    chk("ready", 0, sv);
    @(posedge ref_clk);
    go <= 1'b1;
    periphConnected <= 1'b1;
    for (int i = 0; i < 300 && words < 3; i++) @(posedge ref_clk);
    repeat (30) @(posedge ref_clk);
    #1;
    chk("words", 3, words);
    chk("done", 1, nDone);
    chk("addr", 7, memAddr);
    chk("busy", 0, selActive);
    $display("t_block done");
  endtask
  task automatic t_stop;
    int w1;
    setup(18'h0_0010, 18'h0_001F, 1'b1);
    for (int i = 0; i < 300 && words < 4; i++) @(posedge ref_clk);
    periphStop <= 1'b1;
    repeat (2) @(posedge ref_clk);
    periphStop <= 1'b0;
    #1;
    w1 = words;
    chk("busy", 0, selActive);
    op(BTC_CMD_SEN, `BTC_SEN_ABNORMAL, NIL);
    chk("abn", 1, sv);
    op(BTC_CMD_XFR, `BTC_XFR_CLR_ABN, NIL);
    op(BTC_CMD_SEN, `BTC_SEN_ABNORMAL, NIL);
    chk("abn", 0, sv);
    chk("words", w1, words);
    op(BTC_CMD_EXC, `BTC_EXC_INIT, NIL);
    op(BTC_CMD_XFR, `BTC_XFR_RD_CUR, NIL);
    chk("cur", 0, rd);
    $display("t_stop done");
  endtask
  task automatic t_halt;
    @(posedge ref_clk);
    prioIn <= 1'b0;
    setup(18'h0_0020, 18'h0_002F, 1'b1);
    repeat (5) @(posedge ref_clk);
    #1;
    chk("memReq", 0, memReq);
    chk("prioOut", 0, prioOut);
    @(posedge ref_clk);
    prioIn <= 1'b1;
    op(BTC_CMD_XFR, `BTC_XFR_STOP, NIL);
    chk("memReq", 0, memReq);
    chk("busy", 0, selActive);
    chk("prioOut", 1, prioOut);
    op(BTC_CMD_XFR, `BTC_XFR_RD_STAT, NIL);
    chk("stat", 0, rd);
    $display("t_halt done");
  endtask
  task automatic t_out;
    setup(18'h0_0040, 18'h0_0040, 1'b0);
    repeat (10) @(posedge ref_clk);
    #1;
    chk("periphDataOut", 18'h0_0040, periphDataOut);
    chk("done", 2, nDone);
    chk("busy", 0, selActive);
    op(BTC_CMD_XFR, `BTC_XFR_RD_FINAL, NIL);
    chk("final", 18'h0_0040, rd);
    op(BTC_CMD_XFR, `BTC_XFR_RD_DEV, NIL);
    chk("dev", 18'h0_0003, rd);
    op(BTC_CMD_XFR, `BTC_XFR_RD_DIR, NIL);
    chk("dir", 0, rd);
    @(posedge ref_clk);
    instrDev <= 6'h01;
    op(BTC_CMD_XFR, `BTC_XFR_RD_CUR, NIL);
    chk("valid", 0, rv);
    @(posedge ref_clk);
    instrDev <= `BTC_OWN_DEV;
    op(BTC_CMD_XFR, 4'hB, NIL);
    chk("valid", 0, rv);
    $display("t_out done");
  endtask
  initial begin
    rst = 1'b1;
    instrStb = 1'b0;
    instrKind = BTC_CMD_NONE;
    instrDev = `BTC_OWN_DEV;
    instrFunc = 4'h0;
    hostDataIn = NIL;
    prioIn = 1'b1;
    memAck = 1'b0;
    memRData = NIL;
    periphConnected = 1'b1;
    periphStop = 1'b0;
    go = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_block;
    t_stop;
    t_halt;
    t_out;
    give_verdict;
  end
endmodule
